// [logic/fepc_codec.v]
// 100 Mb/s coding path: 4b5b, scrambler, nrzi and mlt-3, both directions
// ****************************************
// ****************************************
`timescale 1ns/10ps
`include "fepc_defs.vh"

module fepc_codec #(
  parameter [15:0] SYNC_LIM_BITS = `FEPC_SYNC_LIM
) (
  input wire mclk, // 250 MHz core clock
  input wire rst, // synchronous reset, high
  input wire [4:0] phy_addr, // management address strap
  input wire tx_en, // mac transmit enable
  input wire [3:0] txd, // mac transmit nibble
  input wire tx_er, // mac transmit error
  output wire tx_nib_req, // nibble taken this cycle
  output reg [1:0] tx_level, // mlt-3 level to line
  input wire [1:0] rx_level, // sampled mlt-3 level from line
  output reg [3:0] rxd, // receive nibble
  output reg rx_dv, // receive data valid
  output reg rx_er, // receive error
  output reg crs, // carrier sense
  output reg rx_nib_stb, // new receive nibble pulse
  output reg locked // descrambler in lock
);

  // ****************************************
  // state codes
  // ****************************************
  localparam [3:0] T_IDLE = 4'h1;
  localparam [3:0] T_SSD2 = 4'h2;
  localparam [3:0] T_DATA = 4'h4;
  localparam [3:0] T_ESD2 = 4'h8;
  localparam [5:0] R_IDLE = 6'h01;
  localparam [5:0] R_SSD1 = 6'h02;
  localparam [5:0] R_SSD2 = 6'h04;
  localparam [5:0] R_DATA = 6'h08;
  localparam [5:0] R_ESD2 = 6'h10;
  localparam [5:0] R_BAD = 6'h20;
  localparam integer SYM_DIV_I = `FEPC_SYM_DIV;
  localparam [1:0] SYM_LAST = SYM_DIV_I[1:0] - 2'h1;

  // ****************************************
  // 4b5b tables
  // ****************************************
  function [4:0] enc5;
    input [3:0] n;
    begin
      case (n)
        4'h0: enc5 = 5'h1E;
        4'h1: enc5 = 5'h09;
        4'h2: enc5 = 5'h14;
        4'h3: enc5 = 5'h15;
        4'h4: enc5 = 5'h0A;
        4'h5: enc5 = 5'h0B;
        4'h6: enc5 = 5'h0E;
        4'h7: enc5 = 5'h0F;
        4'h8: enc5 = 5'h12;
        4'h9: enc5 = 5'h13;
        4'hA: enc5 = 5'h16;
        4'hB: enc5 = 5'h17;
        4'hC: enc5 = 5'h1A;
        4'hD: enc5 = 5'h1B;
        4'hE: enc5 = 5'h1C;
        default: enc5 = 5'h1D;
      endcase
    end
  endfunction

  // top bit flags a data code; control and invalid codes give zero
  function [4:0] dec5;
    input [4:0] c;
    integer i;
    begin
      dec5 = 5'h00;
      for (i = 0; i < 16; i = i + 1) begin
        if (enc5(i[3:0]) == c) begin
          dec5 = {1'b1, i[3:0]};
        end
      end
    end
  endfunction

  // ****************************************
  // symbol tick and input synchronisers
  // ****************************************
  reg [1:0] sym_cnt_q;
  reg [1:0] rx_lvl_s1_q;
  reg [1:0] rx_lvl_s2_q;
  reg [4:0] addr_s1_q;
  reg [4:0] addr_s2_q;
  wire tick;

  assign tick = (sym_cnt_q == SYM_LAST);

  always @(posedge mclk) begin
    rx_lvl_s1_q <= rx_level;
    rx_lvl_s2_q <= rx_lvl_s1_q;
    addr_s1_q <= phy_addr;
    addr_s2_q <= addr_s1_q;
    if (rst) begin
      sym_cnt_q <= 2'h0;
    end else begin
      sym_cnt_q <= tick ? 2'h0 : sym_cnt_q + 2'h1;
    end
  end

  // ****************************************
  // transmit path
  // ****************************************
  reg [3:0] tx_st_q;
  reg [2:0] tx_pos_q;
  reg [4:0] tx_sh_q;
  reg [10:0] scr_q;
  reg tx_nrzi_q;
  reg [1:0] mlt_ph_q;
  reg [3:0] tx_st_d;
  reg [4:0] tx_cg_d;
  wire tx_load;
  wire scr_key;
  wire tx_sbit;
  wire tx_nrzi_d;
  wire tx_step;

  assign tx_load = tick && (tx_pos_q == 3'h4);
  assign tx_nib_req = tx_load;
  assign scr_key = scr_q[10] ^ scr_q[8];
  assign tx_sbit = tx_sh_q[4] ^ scr_key;
  assign tx_nrzi_d = tx_nrzi_q ^ tx_sbit;
  assign tx_step = tx_nrzi_d ^ tx_nrzi_q;

  always @* begin
    tx_st_d = tx_st_q;
    tx_cg_d = `FEPC_CG_IDLE;
    case (tx_st_q)
      T_IDLE: begin
        if (tx_en && locked) begin
          tx_cg_d = `FEPC_CG_SSD1;
          tx_st_d = T_SSD2;
        end
      end
      T_SSD2: begin
        tx_cg_d = `FEPC_CG_SSD2;
        tx_st_d = T_DATA;
      end
      T_DATA: begin
        if (tx_en) begin
          tx_cg_d = tx_er ? `FEPC_CG_TXERR : enc5(txd);
        end else begin
          tx_cg_d = `FEPC_CG_ESD1;
          tx_st_d = T_ESD2;
        end
      end
      T_ESD2: begin
        tx_cg_d = `FEPC_CG_ESD2;
        tx_st_d = T_IDLE;
      end
      default: begin
        tx_st_d = T_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      tx_st_q <= T_IDLE;
      tx_pos_q <= 3'h0;
      tx_sh_q <= `FEPC_CG_IDLE;
      scr_q <= {`FEPC_SEED_HI, addr_s2_q};
      tx_nrzi_q <= 1'b0;
      mlt_ph_q <= 2'h0;
      tx_level <= `FEPC_LVL_ZERO;
    end else if (tick) begin
      tx_pos_q <= (tx_pos_q == 3'h4) ? 3'h0 : tx_pos_q + 3'h1;
      scr_q <= {scr_q[9:0], scr_key};
      tx_nrzi_q <= tx_nrzi_d;
      // a one seen as an nrzi change steps the level cycle
      if (tx_step) begin
        mlt_ph_q <= mlt_ph_q + 2'h1;
      end
      case (mlt_ph_q + {1'b0, tx_step})
        2'h1: tx_level <= `FEPC_LVL_POS;
        2'h3: tx_level <= `FEPC_LVL_NEG;
        default: tx_level <= `FEPC_LVL_ZERO;
      endcase
      if (tx_load) begin
        tx_st_q <= tx_st_d;
        tx_sh_q <= tx_cg_d;
      end else begin
        tx_sh_q <= {tx_sh_q[3:0], 1'b0};
      end
    end
  end

  // ****************************************
  // receive line decode and descrambler
  // ****************************************
  reg [1:0] rx_prev_q;
  reg rx_nrzi_q;
  reg [10:0] dsc_q;
  reg [5:0] lock_cnt_q;
  reg [15:0] sync_cnt_q;
  reg [3:0] ones_q;
  wire rx_nrzi_d;
  wire rx_bit;
  wire dsc_key;
  wire plain;

  assign rx_nrzi_d = rx_nrzi_q ^ (rx_lvl_s2_q != rx_prev_q);
  assign rx_bit = rx_nrzi_d ^ rx_nrzi_q;
  assign dsc_key = dsc_q[10] ^ dsc_q[8];
  assign plain = rx_bit ^ dsc_key;

  always @(posedge mclk) begin
    if (rst) begin
      rx_prev_q <= `FEPC_LVL_ZERO;
      rx_nrzi_q <= 1'b0;
      dsc_q <= 11'h000;
      lock_cnt_q <= 6'h00;
      sync_cnt_q <= 16'h0000;
      ones_q <= 4'h0;
      locked <= 1'b0;
    end else if (tick) begin
      rx_prev_q <= rx_lvl_s2_q;
      rx_nrzi_q <= rx_nrzi_d;
      if (!locked) begin
        // idle is all ones, so the inverted line bit is the key
        dsc_q <= {dsc_q[9:0], ~rx_bit};
        if (dsc_key == ~rx_bit) begin
          lock_cnt_q <= lock_cnt_q + 6'h01;
          if (lock_cnt_q == `FEPC_LOCK_BITS) begin
            locked <= 1'b1;
          end
        end else begin
          lock_cnt_q <= 6'h00;
        end
        sync_cnt_q <= 16'h0000;
        ones_q <= 4'h0;
      end else begin
        dsc_q <= {dsc_q[9:0], dsc_key};
        ones_q <= plain ? ((ones_q == 4'hF) ? ones_q : ones_q + 4'h1) : 4'h0;
        // limit sits above the longest frame, so a real loss is needed
        if (ones_q >= `FEPC_IDLE_FULL) begin
          sync_cnt_q <= 16'h0000;
        end else if (sync_cnt_q == SYNC_LIM_BITS) begin
          locked <= 1'b0;
          lock_cnt_q <= 6'h00;
        end else begin
          sync_cnt_q <= sync_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // alignment and 5b4b decode
  // ****************************************
  reg [5:0] rx_st_q;
  reg [2:0] rx_pos_q;
  reg [3:0] rx_win_q;
  reg idle_cnt_q;
  wire [4:0] rx_cg;
  wire [4:0] rx_dec;
  wire rx_bound;
  wire rx_start;

  assign rx_cg = {rx_win_q, plain};
  assign rx_dec = dec5(rx_cg);
  assign rx_bound = tick && locked && (rx_pos_q == 3'h4) && (rx_st_q != R_IDLE);
  // the first zero after idle is the third bit of a start symbol
  assign rx_start = tick && locked && (rx_st_q == R_IDLE) && !plain && (ones_q >= `FEPC_IDLE_RUN);

  always @(posedge mclk) begin
    if (rst || !locked) begin
      rx_st_q <= R_IDLE;
      rx_pos_q <= 3'h0;
      rx_win_q <= 4'h0;
      idle_cnt_q <= 1'b0;
      rxd <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      crs <= 1'b0;
      rx_nib_stb <= 1'b0;
    end else begin
      rx_nib_stb <= rx_bound;
      if (tick) begin
        rx_win_q <= {rx_win_q[2:0], plain};
        rx_pos_q <= (rx_pos_q == 3'h4) ? 3'h0 : rx_pos_q + 3'h1;
      end
      if (rx_start) begin
        rx_pos_q <= 3'h3;
        rx_st_q <= R_SSD1;
        idle_cnt_q <= 1'b0;
      end
      if (rx_bound) begin
        rx_dv <= 1'b1;
        rx_er <= 1'b0;
        crs <= 1'b1;
        idle_cnt_q <= 1'b0;
        case (rx_st_q)
          R_SSD1: begin
            if (rx_cg == `FEPC_CG_SSD1) begin
              rxd <= `FEPC_NIB_PRE;
              rx_st_q <= R_SSD2;
            end else begin
              rxd <= `FEPC_NIB_BADSSD;
              rx_er <= 1'b1;
              rx_dv <= 1'b0;
              rx_st_q <= R_BAD;
            end
          end
          R_SSD2: begin
            if (rx_cg == `FEPC_CG_SSD2) begin
              rxd <= `FEPC_NIB_PRE;
              rx_st_q <= R_DATA;
            end else begin
              rxd <= `FEPC_NIB_BADSSD;
              rx_er <= 1'b1;
              rx_dv <= 1'b0;
              rx_st_q <= R_BAD;
            end
          end
          R_DATA, R_ESD2: begin
            if (rx_st_q == R_ESD2 && rx_cg == `FEPC_CG_ESD2) begin
              rx_dv <= 1'b0;
              crs <= 1'b0;
              rx_st_q <= R_IDLE;
            end else if (rx_cg == `FEPC_CG_ESD1) begin
              rx_dv <= 1'b0;
              rx_er <= (rx_st_q == R_ESD2);
              rx_st_q <= R_ESD2;
            end else if (rx_cg == `FEPC_CG_IDLE && idle_cnt_q) begin
              rx_dv <= 1'b0;
              crs <= 1'b0;
              rx_st_q <= R_IDLE;
            end else begin
              rx_st_q <= R_DATA;
              // second idle closes the frame, so a lone one is an error
              idle_cnt_q <= (rx_cg == `FEPC_CG_IDLE);
              if (rx_dec[4] && rx_st_q == R_DATA) begin
                rxd <= rx_dec[3:0];
              end else begin
                rxd <= `FEPC_NIB_INVAL;
                rx_er <= 1'b1;
              end
            end
          end
          R_BAD: begin
            rxd <= `FEPC_NIB_BADSSD;
            rx_dv <= 1'b0;
            if (rx_cg == `FEPC_CG_IDLE && idle_cnt_q) begin
              crs <= 1'b0;
              rx_st_q <= R_IDLE;
            end else begin
              rx_er <= 1'b1;
              idle_cnt_q <= (rx_cg == `FEPC_CG_IDLE);
            end
          end
          default: begin
            rx_dv <= 1'b0;
            crs <= 1'b0;
            rx_st_q <= R_IDLE;
          end
        endcase
      end
    end
  end

endmodule // fepc_codec

// [inc/fepc_defs.vh]
// constants for the 100 Mb/s physical coding path
`ifndef FEPC_DEFS_VH
`define FEPC_DEFS_VH

// ****************************************
// clocking
// ****************************************
`define FEPC_MCLK_MHZ 250
`define FEPC_SYM_MHZ 125
`define FEPC_SYM_DIV (`FEPC_MCLK_MHZ / `FEPC_SYM_MHZ)

// ****************************************
// control code-groups
// ****************************************
`define FEPC_CG_IDLE 5'h1F
`define FEPC_CG_SSD1 5'h18
`define FEPC_CG_SSD2 5'h11
`define FEPC_CG_ESD1 5'h0D
`define FEPC_CG_ESD2 5'h07
`define FEPC_CG_TXERR 5'h04

// ****************************************
// nibbles shown to the mac
// ****************************************
`define FEPC_NIB_PRE 4'h5
`define FEPC_NIB_BADSSD 4'hE
`define FEPC_NIB_INVAL 4'h0

// ****************************************
// line levels
// ****************************************
`define FEPC_LVL_ZERO 2'h0
`define FEPC_LVL_POS 2'h1
`define FEPC_LVL_NEG 2'h2

// ****************************************
// scrambler and lock
// ****************************************
`define FEPC_SEED_HI 6'h2B
`define FEPC_LOCK_BITS 6'h3C
`define FEPC_IDLE_RUN 4'h7
`define FEPC_IDLE_FULL 4'hA
`define FEPC_SYNC_LIM 16'h8000

`endif

// [verif/fepc_codec_monitor.sv]
// port-level assertion checker for the coding path
`timescale 1ns/10ps
module fepc_codec_monitor #(
  parameter [15:0] SYNC_LIM_BITS = 16'h8000
) (
  input wire mclk, // core clock
  input wire rst, // sync reset
  input wire [4:0] phy_addr, // address strap
  input wire tx_en, // tx enable
  input wire [3:0] txd, // tx nibble
  input wire tx_er, // tx error
  input wire tx_nib_req, // nibble taken
  input wire [1:0] tx_level, // line level out
  input wire [1:0] rx_level, // line level in
  input wire [3:0] rxd, // rx nibble
  input wire rx_dv, // rx valid
  input wire rx_er, // rx error
  input wire crs, // carrier sense
  input wire rx_nib_stb, // rx nibble pulse
  input wire locked // descrambler lock
);
  // ****************
  // helper and checks
  // ****************
  // sign of the last nonzero level, so a repeated sign is caught
  reg [1:0] last_nz_q;
  always @(posedge mclk) begin
    if (rst) begin
      last_nz_q <= 2'h0;
    end else if (tx_level != 2'h0) begin
      last_nz_q <= tx_level;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_LVL_LEGAL: assert property (tx_level != 2'h3)
    else $error("illegal line level");
  AST_MLT_STEP: assert property ($changed(tx_level) |-> $past(tx_level) == 2'h0 || tx_level == 2'h0)
    else $error("level jumped between signs");
  AST_MLT_ALT: assert property (tx_level != 2'h0 && $past(tx_level) == 2'h0 && last_nz_q != 2'h0 |-> tx_level != last_nz_q)
    else $error("level sign repeated");
  AST_TX_HOLD: assert property ($changed(tx_level) |=> $stable(tx_level))
    else $error("line bit shorter than a tick");
  AST_REQ_GAP: assert property (tx_nib_req |=> !tx_nib_req [*8] ##1 !tx_nib_req ##1 tx_nib_req)
    else $error("nibble request spacing wrong");
  // outputs are registered, so they clear one cycle after lock drops
  AST_NO_RX_UNLOCKED: assert property (!locked |=> !rx_dv && !crs && !rx_er)
    else $error("receive activity while unlocked");
  AST_RX_HOLD: assert property (locked && !rx_nib_stb |-> $stable({rxd, rx_dv, rx_er, crs}))
    else $error("receive outputs moved without strobe");
  AST_STB_GAP: assert property (rx_nib_stb && rx_dv |=> !rx_nib_stb [*8])
    else $error("code-group strobes too close");
  AST_DV_CRS: assert property (rx_dv |-> crs)
    else $error("valid without carrier");
  AST_CRS_RISE: assert property ($rose(crs) |-> rx_dv && rxd == 4'h5 || rx_er && rxd == 4'hE)
    else $error("frame start nibble wrong");
endmodule // fepc_codec_monitor

bind fepc_codec fepc_codec_monitor #(.SYNC_LIM_BITS(SYNC_LIM_BITS)) u_fepc_codec_monitor (.mclk(mclk), .rst(rst),
  .phy_addr(phy_addr), .tx_en(tx_en), .txd(txd), .tx_er(tx_er), .tx_nib_req(tx_nib_req), .tx_level(tx_level),
  .rx_level(rx_level), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .rx_nib_stb(rx_nib_stb),
  .locked(locked));

// [verif/fepc_mac_model.sv]
// mac-side partner: feeds transmit nibbles, logs receive nibbles
`timescale 1ns/10ps
module fepc_mac_model (
  input wire mclk, // core clock
  input wire tx_nib_req, // codec takes a nibble
  output reg tx_en, // transmit enable
  output reg [3:0] txd, // transmit nibble
  output reg tx_er, // transmit error
  input wire [3:0] rxd, // receive nibble
  input wire rx_dv, // receive valid
  input wire rx_er, // receive error
  input wire crs, // carrier sense
  input wire rx_nib_stb // receive strobe
);
  logic [5:0] txq[$]; // {en, er, nibble}
  logic [6:0] rxq[$]; // {crs, er, dv, nibble}
  logic [5:0] nxt;
  reg crs_q = 1'b0;
  initial begin
    tx_en = 1'b0;
    txd = 4'h0;
    tx_er = 1'b0;
  end
  // ****************
  // transmit and receive sides
  // ****************
  // nibble set half a cycle before the edge that takes it
  always @(negedge mclk) begin
    if (tx_nib_req) begin
      nxt = (txq.size() > 0) ? txq.pop_front() : 6'h00;
      tx_en <= nxt[5];
      tx_er <= nxt[4];
      // idle nibble lines invert the last nibble at each request
      txd <= nxt[5] ? nxt[3:0] : ~txd;
    end
  end
  // only frame nibbles are kept, plus the one that ends carrier
  always @(posedge mclk) begin
    if (rx_nib_stb) begin
      if (crs || crs_q) rxq.push_back({crs, rx_er, rx_dv, rxd});
      crs_q <= crs;
    end
  end
endmodule // fepc_mac_model

// [verif/fepc_codec_tb.sv]
// self-checking bench: loopback frames and line-side code injection
`timescale 1ns/10ps
module fepc_codec_tb;
  // ****************
  // clock, wiring and line source
  // ****************
  reg mclk;
  reg rst = 1'b1;
  reg [4:0] phy_addr = 5'h03;
  reg [1:0] rx_level = 2'h0;
  reg loop_q = 1'b1;
  wire tx_en;
  wire [3:0] txd;
  wire tx_er;
  wire tx_nib_req;
  wire [1:0] tx_level;
  wire [3:0] rxd;
  wire rx_dv;
  wire rx_er;
  wire crs;
  wire rx_nib_stb;
  wire locked;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] exp_q[$]; // {rxd care, crs, er, dv, nibble}
  bit gen_bits[$];
  reg [10:0] gen_s_q = 11'h5A3;
  reg gen_nrzi_q = 1'b0;
  reg gen_sgn_q = 1'b0;
  reg gen_ph_q = 1'b0;
  reg [1:0] gen_lvl_q = 2'h0;
  bit gbit;
  bit key;
  bit nz;
  logic [127:0] cap_a;
  logic [127:0] cap_b;

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  fepc_codec #(.SYNC_LIM_BITS(16'h0100)) u_fepc_codec (.mclk(mclk), .rst(rst), .phy_addr(phy_addr),
    .tx_en(tx_en), .txd(txd), .tx_er(tx_er), .tx_nib_req(tx_nib_req), .tx_level(tx_level),
    .rx_level(rx_level), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .rx_nib_stb(rx_nib_stb),
    .locked(locked));
  fepc_mac_model u_fepc_mac_model (.mclk(mclk), .tx_nib_req(tx_nib_req), .tx_en(tx_en), .txd(txd),
    .tx_er(tx_er), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .rx_nib_stb(rx_nib_stb));

  // far-end transmitter: own key stream, idles when nothing queued
  always @(negedge mclk) begin
    gen_ph_q <= ~gen_ph_q;
    if (gen_ph_q) begin
      gbit = (gen_bits.size() > 0) ? gen_bits.pop_front() : 1'b1;
      key = gen_s_q[10] ^ gen_s_q[8];
      gen_s_q <= {gen_s_q[9:0], key};
      nz = gen_nrzi_q ^ gbit ^ key;
      gen_nrzi_q <= nz;
      // mlt-3 steps on a change of the nrzi level, not on the level itself
      if ((nz ^ gen_nrzi_q) && gen_lvl_q == 2'h0) begin
        gen_lvl_q <= gen_sgn_q ? 2'h2 : 2'h1;
        gen_sgn_q <= ~gen_sgn_q;
      end else if (nz ^ gen_nrzi_q) begin
        gen_lvl_q <= 2'h0;
      end
    end
    rx_level <= loop_q ? tx_level : gen_lvl_q;
  end

  // ****************
  // shared tasks
  // ****************
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task do_reset(input logic [4:0] addr, input logic lp);
    rst = 1'b1;
    phy_addr = addr;
    loop_q = lp;
    repeat (16) @(negedge mclk);
    chk("reset outputs", {tx_level, rxd, rx_dv, rx_er, crs, rx_nib_stb, locked}, 0);
    rst = 1'b0;
  endtask

  task wait_lock();
    for (int i = 0; i < 3000 && locked !== 1'b1; i++) @(negedge mclk);
    chk("lock", locked, 1);
    // start detection wants a run of idles seen after lock
    repeat (40) @(negedge mclk);
  endtask

  task capture(output logic [127:0] c);
    c = 0;
    repeat (64) begin
      repeat (2) @(negedge mclk);
      c = {c[125:0], tx_level};
    end
  endtask

  task check_frame(input string nm);
    int i;
    for (i = 0; i < 1500 && u_fepc_mac_model.rxq.size() < exp_q.size(); i++) @(negedge mclk);
    repeat (40) @(negedge mclk);
    chk({nm, " count"}, u_fepc_mac_model.rxq.size(), exp_q.size());
    for (i = 0; i < exp_q.size() && i < u_fepc_mac_model.rxq.size(); i++) begin
      chk({nm, " flags"}, u_fepc_mac_model.rxq[i][6:4], exp_q[i][6:4]);
      if (exp_q[i][7]) chk({nm, " nibble"}, u_fepc_mac_model.rxq[i][3:0], exp_q[i][3:0]);
    end
    u_fepc_mac_model.rxq.delete();
    exp_q.delete();
    $display("test %s done", nm);
  endtask

  // ****************
  // scenarios
  // ****************
  task test_seed();
    do_reset(5'h03, 1'b1);
    capture(cap_a);
    do_reset(5'h1C, 1'b1);
    capture(cap_b);
    chk("seed streams differ", cap_a != cap_b, 1);
    $display("test seed done");
  endtask

  task test_loop_frame();
    wait_lock();
    u_fepc_mac_model.rxq.delete();
    repeat (2) u_fepc_mac_model.txq.push_back(6'h25);
    repeat (2) exp_q.push_back(8'hD5);
    for (int n = 0; n < 16; n++) begin
      u_fepc_mac_model.txq.push_back({2'h2, n[3:0]});
      exp_q.push_back({4'hD, n[3:0]});
    end
    u_fepc_mac_model.txq.push_back(6'h30);
    exp_q.push_back(8'hF0);
    exp_q.push_back(8'h40);
    exp_q.push_back(8'h00);
    check_frame("loop frame");
  endtask

  task test_line_codes();
    logic [4:0] cg [0:15];
    logic [7:0] ex [0:15];
    cg = '{5'h18, 5'h11, 5'h09, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h11, 5'h07, 5'h18, 5'h1F, 5'h14,
      5'h0D, 5'h1F, 5'h1F};
    ex = '{8'hD5, 8'hD5, 8'hD1, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hF0, 8'hD2,
      8'h40, 8'hF0, 8'h00};
    do_reset(5'h1C, 1'b0);
    wait_lock();
    u_fepc_mac_model.rxq.delete();
    for (int k = 0; k < 16; k++) begin
      for (int b = 4; b >= 0; b--) gen_bits.push_back(cg[k][b]);
      exp_q.push_back(ex[k]);
    end
    check_frame("line codes");
  endtask

  task test_bad_start();
    for (int b = 14; b >= 0; b--) gen_bits.push_back(b != 12 && b != 10 && b != 9);
    // the first idle after a bad start still shows the error nibble
    repeat (3) exp_q.push_back(8'hEE);
    exp_q.push_back(8'h00);
    check_frame("bad start");
  endtask

  // long run with no idles must drop lock, then idles must win it back
  task test_relock();
    int i;
    for (i = 0; i < 300; i++) gen_bits.push_back(1'b0);
    for (i = 0; i < 1500 && locked === 1'b1; i++) @(negedge mclk);
    chk("lock lost", locked, 0);
    repeat (2) @(negedge mclk);
    chk("receive while unlocked", {crs, rx_dv, rx_er}, 0);
    wait_lock();
    u_fepc_mac_model.rxq.delete();
    $display("test relock done");
  endtask

  initial begin
    #(4 * 40000);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    test_seed();
    test_loop_frame();
    test_line_codes();
    test_bad_start();
    test_relock();
    summarize();
  end
endmodule // fepc_codec_tb
